// >>> logic/width_term_map.svh
// width_term_map.svh: field positions, reset values and counts for
// the width and termination configuration block.
// assumes: included by bare name from the package and the design.
`ifndef WIDTH_TERM_MAP_SVH
`define WIDTH_TERM_MAP_SVH

// mode register width
`define MODE_REG_W      12

// data configuration: data termination field
`define DCFG_TERM_MSB   3
`define DCFG_TERM_LSB   2

// write-clock configuration: termination field
`define WCFG_TERM_MSB   11
`define WCFG_TERM_LSB   10

// command termination configuration
`define CTERM_OVR_BIT   4
`define CTERM_UP_MSB    3
`define CTERM_UP_LSB    2
`define CTERM_LOW_MSB   1
`define CTERM_LOW_LSB   0

// termination codes
`define TERM_OFF        2'h0
`define TERM_LOW_RSVD   2'h3

// reset values
`define STRAP_RST       4'h0
`define CNT_RST         2'h0
`define FLAG_RST        1'b0

// enabled cycles after reset release before strap sampling
`define SETTLE_CYC      2'h3

`endif

// >>> logic/width_term_pkg.sv
// width_term_pkg.sv: types for the width and termination block.
// assumes: width_term_map.svh is on the include path.
package width_term_pkg;
  `include "width_term_map.svh"

  typedef logic [1:0] term_t;

  typedef enum logic [1:0] {
    CFG_SETTLE,
    CFG_SAMPLE,
    CFG_LOCKED
  } cfg_state_t;

endpackage : width_term_pkg

// >>> logic/width_and_termination_config.sv
// width_and_termination_config.sv: power-up width and pseudo-channel
// strap capture, and routing of termination fields to the receivers.
// assumes: strap pins are asynchronous; mode register contents and the
// initialization termination values come from logic on clk_i.
//
// What this block does
// - grounded error straps select byte-wide mode
// - width latched after reset release and three settle cycles
// - width fixed after latching
// - unused byte high impedance, termination off
// - enabled termination connects receiver to supply
// - data termination per byte, secondary forced off in byte-wide mode
// - write clock termination, disabled pair forced off
// - upper command termination independent of lower
// - bit six low both channels: pseudo-channel
// - pseudo-channel shares upper bus, same commands
// - override clear uses initialization termination
// - override set uses register termination fields
// - lower termination reserved code treated disabled
`timescale 1ns/1ps
`include "width_term_map.svh"

module width_and_termination_config
  import width_term_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   chan_a_second_byte_error_pin_i,
  input  wire logic                   chan_b_first_byte_error_pin_i,
  input  wire logic                   command_bus_bit_six_a_i,
  input  wire logic                   command_bus_bit_six_b_i,
  input  wire logic [`MODE_REG_W-1:0] data_config_reg_i,
  input  wire logic [`MODE_REG_W-1:0] write_clock_config_reg_i,
  input  wire logic [`MODE_REG_W-1:0] command_termination_config_reg_i,
  input  wire term_t                  init_upper_term_i,
  input  wire term_t                  init_lower_term_i,
  output logic                        cfg_locked_o,
  output logic                        byte_wide_o,
  output logic                        pseudo_channel_o,
  output logic                        secondary_byte_enable_o,
  output term_t                       data_term_pri_a_o,
  output term_t                       data_term_sec_a_o,
  output term_t                       data_term_pri_b_o,
  output term_t                       data_term_sec_b_o,
  output term_t                       write_clock_term_pri_a_o,
  output term_t                       write_clock_term_sec_a_o,
  output term_t                       write_clock_term_pri_b_o,
  output term_t                       write_clock_term_sec_b_o,
  output term_t                       upper_command_termination_o,
  output term_t                       lower_command_termination_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // pass a termination code only while the receiver is in use
  function automatic term_t term_gate(input term_t code, input logic keep);
    term_gate = keep ? code : `TERM_OFF;
  endfunction : term_gate

  // lower command code: reserved reads as disabled
  function automatic term_t lower_decode(input term_t code);
    lower_decode = (code == `TERM_LOW_RSVD) ? `TERM_OFF : code;
  endfunction : lower_decode

  // ----------------------------------------------------------------
  // strap synchronisers
  // ----------------------------------------------------------------

  // bit 3: chan A second byte, 2: chan B first byte, 1/0: bit six A/B
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  logic [3:0] strap_s3_r;
  logic [3:0] strap_s1_nxt;
  logic [3:0] strap_s2_nxt;
  logic [3:0] strap_s3_nxt;
  logic       strap_agree;

  always_comb begin
    strap_s1_nxt = strap_s1_r;
    strap_s2_nxt = strap_s2_r;
    strap_s3_nxt = strap_s3_r;
    if (clk_en_i) begin
      strap_s1_nxt = {chan_a_second_byte_error_pin_i,
                      chan_b_first_byte_error_pin_i,
                      command_bus_bit_six_a_i,
                      command_bus_bit_six_b_i};
      strap_s2_nxt = strap_s1_r;
      strap_s3_nxt = strap_s2_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_s1_r <= `STRAP_RST;
      strap_s2_r <= `STRAP_RST;
      strap_s3_r <= `STRAP_RST;
    end else begin
      strap_s1_r <= strap_s1_nxt;
      strap_s2_r <= strap_s2_nxt;
      strap_s3_r <= strap_s3_nxt;
    end
  end

  assign strap_agree = (strap_s2_r == strap_s3_r);

  // ----------------------------------------------------------------
  // configuration capture
  // ----------------------------------------------------------------

  cfg_state_t state_r;
  cfg_state_t state_nxt;
  logic [1:0] settle_cnt_r;
  logic [1:0] settle_cnt_nxt;
  logic       byte_wide_r;
  logic       byte_wide_nxt;
  logic       pseudo_r;
  logic       pseudo_nxt;
  logic       strap_x8;
  logic       strap_pc;

  assign strap_x8 = ~strap_s3_r[3] & ~strap_s3_r[2];
  assign strap_pc = ~strap_s3_r[1] & ~strap_s3_r[0];

  always_comb begin
    state_nxt      = state_r;
    settle_cnt_nxt = settle_cnt_r;
    byte_wide_nxt  = byte_wide_r;
    pseudo_nxt     = pseudo_r;
    if (clk_en_i) begin
      unique case (state_r)
        CFG_SETTLE: begin
          settle_cnt_nxt = settle_cnt_r + 2'h1;
          if (settle_cnt_r == `SETTLE_CYC - 2'h1) begin
            state_nxt = CFG_SAMPLE;
          end
        end
        CFG_SAMPLE: begin
          if (strap_agree) begin
            byte_wide_nxt = strap_x8;
            pseudo_nxt    = strap_pc;
            state_nxt     = CFG_LOCKED;
          end
        end
        CFG_LOCKED: begin
          state_nxt = CFG_LOCKED;
        end
        default: begin
          state_nxt = CFG_SETTLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r      <= CFG_SETTLE;
      settle_cnt_r <= `CNT_RST;
      byte_wide_r  <= `FLAG_RST;
      pseudo_r     <= `FLAG_RST;
    end else begin
      state_r      <= state_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      byte_wide_r  <= byte_wide_nxt;
      pseudo_r     <= pseudo_nxt;
    end
  end

  // ----------------------------------------------------------------
  // termination routing
  // ----------------------------------------------------------------

  logic  locked;
  logic  word_wide;
  logic  ovr;
  term_t dq_field;
  term_t wck_field;
  term_t up_field;
  term_t low_field;
  logic  sec_en_nxt;
  term_t dq_pri_nxt;
  term_t dq_sec_nxt;
  term_t wck_pri_nxt;
  term_t wck_sec_nxt;
  term_t up_nxt;
  term_t low_nxt;

  assign locked    = (state_r == CFG_LOCKED);
  assign word_wide = locked & ~byte_wide_r;
  assign ovr       = command_termination_config_reg_i[`CTERM_OVR_BIT];
  assign dq_field  = data_config_reg_i[`DCFG_TERM_MSB:`DCFG_TERM_LSB];
  assign wck_field = write_clock_config_reg_i[`WCFG_TERM_MSB:`WCFG_TERM_LSB];
  assign up_field  = command_termination_config_reg_i[`CTERM_UP_MSB:`CTERM_UP_LSB];
  assign low_field = command_termination_config_reg_i[`CTERM_LOW_MSB:`CTERM_LOW_LSB];

  always_comb begin
    sec_en_nxt  = secondary_byte_enable_o;
    dq_pri_nxt  = data_term_pri_a_o;
    dq_sec_nxt  = data_term_sec_a_o;
    wck_pri_nxt = write_clock_term_pri_a_o;
    wck_sec_nxt = write_clock_term_sec_a_o;
    up_nxt      = upper_command_termination_o;
    low_nxt     = lower_command_termination_o;
    if (clk_en_i) begin
      sec_en_nxt  = word_wide;
      dq_pri_nxt  = term_gate(dq_field, locked);
      dq_sec_nxt  = term_gate(dq_field, word_wide);
      wck_pri_nxt = term_gate(wck_field, locked);
      wck_sec_nxt = term_gate(wck_field, word_wide);
      up_nxt  = term_gate(ovr ? up_field : init_upper_term_i, locked);
      low_nxt = term_gate(lower_decode(ovr ? low_field : init_lower_term_i), locked);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      secondary_byte_enable_o     <= `FLAG_RST;
      data_term_pri_a_o           <= `TERM_OFF;
      data_term_sec_a_o           <= `TERM_OFF;
      write_clock_term_pri_a_o    <= `TERM_OFF;
      write_clock_term_sec_a_o    <= `TERM_OFF;
      upper_command_termination_o <= `TERM_OFF;
      lower_command_termination_o <= `TERM_OFF;
    end else begin
      secondary_byte_enable_o     <= sec_en_nxt;
      data_term_pri_a_o           <= dq_pri_nxt;
      data_term_sec_a_o           <= dq_sec_nxt;
      write_clock_term_pri_a_o    <= wck_pri_nxt;
      write_clock_term_sec_a_o    <= wck_sec_nxt;
      upper_command_termination_o <= up_nxt;
      lower_command_termination_o <= low_nxt;
    end
  end

  // channel B mirrors channel A: same fields, same disabled byte pairing
  assign data_term_pri_b_o        = data_term_pri_a_o;
  assign data_term_sec_b_o        = data_term_sec_a_o;
  assign write_clock_term_pri_b_o = write_clock_term_pri_a_o;
  assign write_clock_term_sec_b_o = write_clock_term_sec_a_o;
  assign cfg_locked_o             = locked;
  assign byte_wide_o              = byte_wide_r;
  assign pseudo_channel_o         = pseudo_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_width_latch: assert property (
    (state_r == CFG_SAMPLE && clk_en_i && strap_agree)
      |=> (byte_wide_r == $past(strap_x8)) && locked)
    else $error("width not taken from straps");

  a_pc_latch: assert property (
    (state_r == CFG_SAMPLE && clk_en_i && strap_agree)
      |=> pseudo_r == $past(strap_pc))
    else $error("pseudo-channel not taken from straps");

  a_sample_time: assert property (
    $rose(rst_n_i) ##0 clk_en_i [*3] |=> state_r == CFG_SAMPLE)
    else $error("strap sampling not reached after release");

  a_width_fixed: assert property (
    locked |=> locked && $stable(byte_wide_r) && $stable(pseudo_r))
    else $error("latched selection changed");

  a_byte_off: assert property (
    (locked && byte_wide_r) ##1 clk_en_i [*2]
      |-> !secondary_byte_enable_o && data_term_sec_a_o == `TERM_OFF)
    else $error("unused byte still enabled or terminated");

  a_data_term: assert property (
    (locked && clk_en_i && !byte_wide_r)
      |=> data_term_pri_a_o == $past(dq_field) && data_term_sec_a_o == $past(dq_field))
    else $error("data termination not following field");

  a_wck_term: assert property (
    (locked && clk_en_i)
      |=> write_clock_term_pri_a_o == $past(wck_field)
          && (write_clock_term_sec_a_o == `TERM_OFF) == ($past(byte_wide_r) || $past(wck_field) == `TERM_OFF))
    else $error("write clock termination wrong");

  a_cmd_override: assert property (
    (locked && clk_en_i && ovr)
      |=> upper_command_termination_o == $past(up_field))
    else $error("override field not applied");

  a_cmd_init: assert property (
    (locked && clk_en_i && !ovr)
      |=> upper_command_termination_o == $past(init_upper_term_i))
    else $error("initialization termination not applied");

  a_low_rsvd: assert property (
    lower_command_termination_o != `TERM_LOW_RSVD)
    else $error("reserved lower code reached receivers");

  a_state_frozen: assert property (
    !clk_en_i |=> $stable(state_r) && $stable(data_term_pri_a_o))
    else $error("state moved with clock enable low");

endmodule : width_and_termination_config

// >>> bench/ctrl_strap_model.sv
// ctrl_strap_model.sv: board and controller side of the power-up straps.
// assumes: the bench sets the wanted modes while reset is held low.
`timescale 1ns/1ps

module ctrl_strap_model (
  input  wire logic byte_mode_i,
  input  wire logic pc_mode_i,
  input  wire logic mixed_i,
  output logic      err_strap_a_o,
  output logic      err_strap_b_o,
  output logic      bit_six_a_o,
  output logic      bit_six_b_o
);
  // ----------------------------------------
  // error pin straps
  // ----------------------------------------
  // word mode pulls to supply
  // byte mode ties ground
  // mixed_i pulls the channel B straps the other way: a split board
  assign err_strap_a_o = !byte_mode_i;
  assign err_strap_b_o = mixed_i ? byte_mode_i : !byte_mode_i;

  // ----------------------------------------
  // shared command bus straps
  // ----------------------------------------
  // shared bit six low
  assign bit_six_a_o = !pc_mode_i;
  assign bit_six_b_o = mixed_i ? pc_mode_i : !pc_mode_i;
endmodule : ctrl_strap_model

// >>> bench/tb_width_and_termination_config.sv
// tb_width_and_termination_config.sv: self-checking bench for the block.
// assumes: design files and ctrl_strap_model are compiled before this file.
`timescale 1ns/1ps
`include "width_term_map.svh"

`define CHK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
  end \
end

module tb_width_and_termination_config;
  import width_term_pkg::*;
  logic                   clk_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  logic                   clk_en_i = 1'b1;
  logic                   byte_mode = 1'b0;
  logic                   pc_mode = 1'b0;
  logic                   mixed = 1'b0;
  logic                   err_a, err_b, six_a, six_b;
  logic [`MODE_REG_W-1:0] dcfg = 12'h000;
  logic [`MODE_REG_W-1:0] wcfg = 12'h000;
  logic [`MODE_REG_W-1:0] ccfg = 12'h000;
  term_t                  init_up = 2'h0;
  term_t                  init_low = 2'h0;
  logic                   locked, bw_o, pc_o, sec_en;
  term_t                  dpa, dsa, dpb, dsb, wpa, wsa, wpb, wsb, up_o, low_o;
  int                     failures = 0;
  int                     samples_checked = 0;

  always #25 clk_i = ~clk_i;

  ctrl_strap_model ctrl_strap_model_i (.byte_mode_i(byte_mode), .pc_mode_i(pc_mode), .err_strap_a_o(err_a),
    .mixed_i(mixed), .err_strap_b_o(err_b), .bit_six_a_o(six_a), .bit_six_b_o(six_b));

  width_and_termination_config width_and_termination_config_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i), .chan_a_second_byte_error_pin_i(err_a), .chan_b_first_byte_error_pin_i(err_b),
    .command_bus_bit_six_a_i(six_a), .command_bus_bit_six_b_i(six_b), .data_config_reg_i(dcfg),
    .write_clock_config_reg_i(wcfg), .command_termination_config_reg_i(ccfg), .init_upper_term_i(init_up),
    .init_lower_term_i(init_low), .cfg_locked_o(locked), .byte_wide_o(bw_o), .pseudo_channel_o(pc_o),
    .secondary_byte_enable_o(sec_en), .data_term_pri_a_o(dpa), .data_term_sec_a_o(dsa),
    .data_term_pri_b_o(dpb), .data_term_sec_b_o(dsb), .write_clock_term_pri_a_o(wpa),
    .write_clock_term_sec_a_o(wsa), .write_clock_term_pri_b_o(wpb), .write_clock_term_sec_b_o(wsb),
    .upper_command_termination_o(up_o), .lower_command_termination_o(low_o));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : step

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic apply_reset(input logic bw, input logic pc);
    int   n;
    logic ebw;
    logic epc;
    ebw = bw & !mixed;
    epc = pc & !mixed;
    rst_n_i = 1'b0;
    byte_mode = bw;
    pc_mode = pc;
    step(4);
    `CHK("locked_in_reset", 1'b0, locked)
    `CHK("width_in_reset", 1'b0, bw_o)
    `CHK("pseudo_in_reset", 1'b0, pc_o)
    rst_n_i = 1'b1;
    n = 0;
    while (locked !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    `CHK("locked", 1'b1, locked)
    `CHK("term_before_lock", 2'h0, dpa)
    `CHK("width", ebw, bw_o)
    `CHK("pseudo", epc, pc_o)
    step(2);
    `CHK("sec_enable", !ebw, sec_en)
  endtask : apply_reset

  // one strap of each pair disagrees: word-wide and normal mode expected
  task automatic mixed_straps();
    mixed = 1'b1;
    apply_reset(1'b1, 1'b1);
    mixed = 1'b0;
  endtask : mixed_straps

  task automatic straps_fixed();
    byte_mode = !byte_mode;
    pc_mode = !pc_mode;
    step(10);
    `CHK("width_held", !byte_mode, bw_o)
    `CHK("pseudo_held", !pc_mode, pc_o)
  endtask : straps_fixed

  task automatic data_terms(input logic bw);
    term_t c;
    term_t s;
    for (int i = 0; i < 4; i++) begin
      c = term_t'(i);
      s = bw ? `TERM_OFF : c;
      dcfg = {8'h00, c, 2'h0};
      wcfg = {c, 10'h000};
      step(2);
      `CHK("data_pri_a", c, dpa)
      `CHK("data_pri_b", c, dpb)
      `CHK("data_sec_a", s, dsa)
      `CHK("data_sec_b", s, dsb)
      `CHK("wck_pri_a", c, wpa)
      `CHK("wck_pri_b", c, wpb)
      `CHK("wck_sec_a", s, wsa)
      `CHK("wck_sec_b", s, wsb)
    end
  endtask : data_terms

  task automatic cmd_terms();
    term_t u;
    term_t l;
    for (int i = 0; i < 4; i++) begin
      u = term_t'(i);
      l = term_t'(3 - i);
      init_up = u;
      init_low = u;
      ccfg = {7'h00, 1'b0, l, u};
      step(2);
      `CHK("cmd_up_init", u, up_o)
      `CHK("cmd_low_init", (u == `TERM_LOW_RSVD) ? `TERM_OFF : u, low_o)
      init_up = l;
      init_low = l;
      ccfg = {7'h00, 1'b1, u, l};
      step(2);
      `CHK("cmd_up_ovr", u, up_o)
      `CHK("cmd_low_ovr", (l == `TERM_LOW_RSVD) ? `TERM_OFF : l, low_o)
    end
  endtask : cmd_terms

  task automatic enable_freeze();
    clk_en_i = 1'b0;
    dcfg = 12'h000;
    step(3);
    `CHK("frozen_pri", 2'h3, dpa)
    clk_en_i = 1'b1;
    step(2);
    `CHK("thawed_pri", 2'h0, dpa)
  endtask : enable_freeze

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    apply_reset(1'b0, 1'b0);
    data_terms(1'b0);
    cmd_terms();
    apply_reset(1'b1, 1'b1);
    data_terms(1'b1);
    cmd_terms();
    enable_freeze();
    straps_fixed();
    mixed_straps();
    apply_reset(1'b1, 1'b0);
    apply_reset(1'b0, 1'b1);
    final_report();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    final_report();
  end
endmodule : tb_width_and_termination_config
